// File: design/lfp_pkg.sv
// Constants shared by the shared-pin control block and its configuration bank.
// Assumes one 200 MHz clock and all field pins sampled into that domain.
package lfp_pkg;
	localparam int unsigned CLK_MHZ = 200;
	localparam int unsigned ALARM_TIME_US = 32000;
	localparam int unsigned ALARM_CYC = ALARM_TIME_US * CLK_MHZ;
	localparam int unsigned CMD_W = 3;
	localparam int unsigned ADDR_W = 3;
	localparam int unsigned DATA_W = 9;
	localparam logic [3:0] HDR_BITS = 4'h6;
	localparam logic [3:0] FRAME_BITS = 4'hF;
	localparam logic [2:0] CMD_CLAMP_ON = 3'h1;
	localparam logic [2:0] CMD_CLAMP_OFF = 3'h2;
	localparam logic [2:0] CMD_READ = 3'h3;
	localparam logic [2:0] CMD_WRITE = 3'h4;
	localparam logic [2:0] ADDR_CHAN = 3'h0;
	localparam logic [2:0] ADDR_OUT = 3'h1;
	localparam logic [2:0] ADDR_STATUS = 3'h7;
	localparam logic [8:0] CFG_RESET = 9'h001;
	localparam int unsigned CH_EN_LSB = 6;
	localparam int unsigned OUT_SEL_LSB = 6;
	localparam int unsigned OEF_EN_BIT = 8;
	localparam logic [1:0] OUT_DEMOD = 2'h0;
	localparam logic [1:0] OUT_CARRIER = 2'h1;
	localparam logic [1:0] OUT_RSSI = 2'h2;
	localparam int unsigned N_SYNC = 7;
	typedef enum logic [1:0] {SL_IDLE, SL_HDR, SL_READ, SL_WDATA} lfp_link_st_t;
endpackage : lfp_pkg

// File: design/lfp_cfg_bank.sv
// Seven nine-bit configuration rows plus a status row, with odd row parity check on the seven.
// Assumes write strobes from the serial engine on the same clock.
`timescale 1ns/1ps
module lfp_cfg_bank import lfp_pkg::*; (
	input wire logic clk,
	input wire logic srst,
	input wire logic wr_en,
	input wire logic [2:0] addr,
	input wire logic [8:0] wdata,
	input wire logic [8:0] status,
	output logic [8:0] rdata,
	output logic [8:0] row0,
	output logic [8:0] row1,
	output logic perr
);
	logic [8:0] rows_q [0:6];
	logic [6:0] bad;
	genvar gi;
	generate
		for (gi = 0; gi < 7; gi++) begin : g_row
			always_ff @(posedge clk) begin
				if (srst) begin
					rows_q[gi] <= CFG_RESET;
				// Status row has no storage, so writes to it fall away
				end else if (wr_en && addr == 3'(gi)) begin
					rows_q[gi] <= wdata;
				end
			end
			assign bad[gi] = ~^rows_q[gi];
		end
	endgenerate
	assign rdata = (addr == ADDR_STATUS) ? status : rows_q[addr];
	assign row0 = rows_q[0];
	assign row1 = rows_q[1];
	assign perr = |bad;
endmodule : lfp_cfg_bank

// File: design/lfp_pin_ctrl.sv
// Shared-pin control: serial programming link versus alert and data outputs.
// Assumes host drives cs_n, sclk and sdio; field signals arrive asynchronously.
//
// Overview of operation
// - Chip select low selects serial programming mode
// - Clock pin is clock in low, alert high
// - Alert low on parity error or alarm expiry
// - Data pin outputs demod or carrier per selection
// - Data pin is serial data when selected
// - Carrier output only after gain control settles
// - Alert only pulls low, never drives high
// - Strength sink active only when option chosen
// - Inactivity flag shown only with filter disabled
// - Nine-bit rows with parity checked for alert
// - All rows writable except read-only status
// - Clamp commands affect only enabled channels
`timescale 1ns/1ps
module lfp_pin_ctrl import lfp_pkg::*; #(
	parameter int unsigned ALARM_CYCLES = ALARM_CYC
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic cs_n_i,
	input wire logic sclk_i,
	input wire logic sdio_i,
	input wire logic demod_i,
	input wire logic carrier_i,
	input wire logic agc_settled_i,
	input wire logic inact_tmo_i,
	output logic alert_o,
	output logic alert_oe_n,
	output logic demod_data_out,
	output logic data_oe_n,
	output logic rssi_sink_en,
	output logic [2:0] clamp_o,
	output logic [2:0] ch_en_o
);
	////////////////////////////////////////////////////////////////////////
	logic [N_SYNC-1:0] raw, s1_q, s2_q;
	logic sclk_prev_q, cs_prev_q;
	logic cs_lo, sclk_s, sdio_s, dem_s, car_s, agc_s, ina_s;
	logic sclk_rise, sclk_fall, cs_fell;
	logic [2:0] alert_hist_q;
	logic sclk_quiet;
	assign raw = {inact_tmo_i, agc_settled_i, carrier_i, demod_i, sdio_i, sclk_i, cs_n_i};
	genvar gi;
	generate
		for (gi = 0; gi < N_SYNC; gi++) begin : g_sync
			always_ff @(posedge clk) begin
				if (srst) begin
					// Chip select and clock pins both idle high
					s1_q[gi] <= (gi <= 1);
					s2_q[gi] <= (gi <= 1);
				end else begin
					s1_q[gi] <= raw[gi];
					s2_q[gi] <= s1_q[gi];
				end
			end
		end
	endgenerate
	assign {ina_s, agc_s, car_s, dem_s, sdio_s, sclk_s} = s2_q[6:1];
	assign cs_lo = ~s2_q[0];
	always_ff @(posedge clk) begin
		if (srst) begin
			sclk_prev_q <= 1'b1;
			cs_prev_q <= 1'b0;
		end else begin
			// Own alert drive echoes through the synchroniser; read it as pull-up
			sclk_prev_q <= sclk_quiet ? sclk_s : 1'b1;
			cs_prev_q <= cs_lo;
		end
	end
	always_ff @(posedge clk) begin
		if (srst) begin
			alert_hist_q <= 3'h0;
		end else begin
			alert_hist_q <= {alert_hist_q[1:0], ~alert_oe_n};
		end
	end
	assign sclk_quiet = ~|alert_hist_q;
	assign sclk_rise = cs_lo & sclk_quiet & sclk_s & ~sclk_prev_q;
	assign sclk_fall = cs_lo & sclk_quiet & ~sclk_s & sclk_prev_q;
	assign cs_fell = cs_lo & ~cs_prev_q;

	////////////////////////////////////////////////////////////////////////
	lfp_link_st_t st_q;
	logic [3:0] cnt_q;
	logic [11:0] sh_in_q;
	logic [8:0] sh_out_q;
	logic wr_en_q, cmd_done_q;
	logic [8:0] rdata, row0, row1, status;
	logic perr, alarm_q;
	logic [2:0] hdr_cmd, hdr_addr;
	assign hdr_cmd = sh_in_q[4:2];
	assign hdr_addr = {sh_in_q[1:0], sdio_s};
	assign status = {alarm_q, perr, 7'h00};
	// Command and address sit in the first six bits of each frame
	always_ff @(posedge clk) begin
		if (srst || !cs_lo || cs_fell) begin
			st_q <= cs_lo ? SL_HDR : SL_IDLE;
			cnt_q <= 4'h0;
		end else if (sclk_rise) begin
			cnt_q <= cnt_q + 4'h1;
			if (st_q == SL_HDR && cnt_q == HDR_BITS - 4'h1) begin
				st_q <= hdr_cmd == CMD_READ ? SL_READ : hdr_cmd == CMD_WRITE ? SL_WDATA : SL_IDLE;
			end else if (cnt_q == FRAME_BITS - 4'h1) begin
				st_q <= SL_IDLE;
			end
		end
	end
	always_ff @(posedge clk) begin
		if (srst) begin
			sh_in_q <= 12'h000;
		end else if (sclk_rise) begin
			sh_in_q <= {sh_in_q[10:0], sdio_s};
		end
	end
	always_ff @(posedge clk) begin
		if (srst) begin
			wr_en_q <= 1'b0;
			cmd_done_q <= 1'b0;
		end else begin
			wr_en_q <= sclk_rise && st_q == SL_WDATA && cnt_q == FRAME_BITS - 4'h1;
			cmd_done_q <= sclk_rise && st_q == SL_HDR && cnt_q == HDR_BITS - 4'h1;
		end
	end
	lfp_cfg_bank u_bank (
		.clk(clk),
		.srst(srst),
		.wr_en(wr_en_q),
		.addr(st_q == SL_HDR ? hdr_addr : sh_in_q[11:9]),
		.wdata(sh_in_q[8:0]),
		.status(status),
		.rdata(rdata),
		.row0(row0),
		.row1(row1),
		.perr(perr)
	);
	// Read data launches on falling clock; host samples it just after the next fall
	always_ff @(posedge clk) begin
		if (srst) begin
			sh_out_q <= 9'h000;
		end else if (sclk_rise && st_q == SL_HDR && cnt_q == HDR_BITS - 4'h1) begin
			sh_out_q <= rdata;
		end else if (sclk_fall && st_q == SL_READ) begin
			sh_out_q <= {sh_out_q[7:0], 1'b0};
		end
	end

	////////////////////////////////////////////////////////////////////////
	logic [2:0] ch_en;
	logic [1:0] out_sel;
	logic oef_en;
	logic [31:0] alarm_cnt_q;
	assign ch_en = row0[CH_EN_LSB +: 3];
	assign out_sel = row1[OUT_SEL_LSB +: 2];
	assign oef_en = row1[OEF_EN_BIT];
	always_ff @(posedge clk) begin
		if (srst) begin
			clamp_o <= 3'h0;
		end else if (cmd_done_q && sh_in_q[5:3] == CMD_CLAMP_ON) begin
			clamp_o <= clamp_o | ch_en;
		end else if (cmd_done_q && sh_in_q[5:3] == CMD_CLAMP_OFF) begin
			clamp_o <= clamp_o & ~ch_en;
		end
	end
	// Alarm restarts on every host command; flag clears on status read
	always_ff @(posedge clk) begin
		if (srst || cmd_done_q) begin
			alarm_cnt_q <= 32'h0;
		end else if (alarm_cnt_q != ALARM_CYCLES) begin
			alarm_cnt_q <= alarm_cnt_q + 32'h1;
		end
	end
	always_ff @(posedge clk) begin
		if (srst) begin
			alarm_q <= 1'b0;
		end else if (alarm_cnt_q == ALARM_CYCLES - 1) begin
			alarm_q <= 1'b1;
		end else if (cmd_done_q && sh_in_q[5:3] == CMD_READ && sh_in_q[2:0] == ADDR_STATUS) begin
			alarm_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// All pin outputs registered so role changes cannot glitch
	always_ff @(posedge clk) begin
		if (srst) begin
			alert_o <= 1'b0;
			alert_oe_n <= 1'b1;
			demod_data_out <= 1'b0;
			data_oe_n <= 1'b1;
			rssi_sink_en <= 1'b0;
			ch_en_o <= 3'h0;
		end else begin
			alert_o <= 1'b0;
			alert_oe_n <= ~(~cs_lo & (perr | alarm_q));
			rssi_sink_en <= out_sel == OUT_RSSI;
			ch_en_o <= ch_en;
			if (cs_lo) begin
				data_oe_n <= ~(st_q == SL_READ);
				demod_data_out <= sh_out_q[8];
			end else begin
				data_oe_n <= 1'b0;
				if (out_sel == OUT_CARRIER) begin
					demod_data_out <= car_s & agc_s;
				end else begin
					demod_data_out <= dem_s | (ina_s & ~oef_en);
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	sequence s_read_hdr;
		sclk_rise && st_q == SL_HDR && cnt_q == HDR_BITS - 4'h1 && hdr_cmd == CMD_READ;
	endsequence
	sequence s_driving;
		!data_oe_n;
	endsequence
	property p_serial_no_alert;
		@(posedge clk) disable iff (srst) cs_lo |=> alert_oe_n;
	endproperty
	a_serial_no_alert: assert property (p_serial_no_alert) else $error("alert driven in serial mode");
	property p_alert_low;
		@(posedge clk) disable iff (srst) (!cs_lo && (perr || alarm_q)) |=> !alert_oe_n;
	endproperty
	a_alert_low: assert property (p_alert_low) else $error("alert not asserted");
	property p_alarm_set;
		@(posedge clk) disable iff (srst) (alarm_cnt_q == ALARM_CYCLES - 1 && !cmd_done_q) |=> alarm_q;
	endproperty
	a_alarm_set: assert property (p_alarm_set) else $error("alarm flag missed expiry");
	property p_demod_out;
		@(posedge clk) disable iff (srst)
			(!cs_lo && out_sel == OUT_DEMOD && !ina_s) |=> (demod_data_out == $past(dem_s) && !data_oe_n);
	endproperty
	a_demod_out: assert property (p_demod_out) else $error("demod data not routed");
	property p_read_drive;
		@(posedge clk) disable iff (srst) s_read_hdr |=> ##1 s_driving;
	endproperty
	a_read_drive: assert property (p_read_drive) else $error("read data not driven");
	property p_no_drive_idle;
		@(posedge clk) disable iff (srst) (cs_lo && st_q != SL_READ) |=> data_oe_n;
	endproperty
	a_no_drive_idle: assert property (p_no_drive_idle) else $error("data pin driven outside read");
	property p_carrier_gate;
		@(posedge clk) disable iff (srst) (!cs_lo && out_sel == OUT_CARRIER && !agc_s) |=> !demod_data_out;
	endproperty
	a_carrier_gate: assert property (p_carrier_gate) else $error("carrier before settle");
	property p_open_drain;
		@(posedge clk) disable iff (srst) !alert_o;
	endproperty
	a_open_drain: assert property (p_open_drain) else $error("alert driven high");
	property p_rssi_sel;
		@(posedge clk) disable iff (srst) ##1 rssi_sink_en == ($past(out_sel) == OUT_RSSI);
	endproperty
	a_rssi_sel: assert property (p_rssi_sel) else $error("strength sink mismatch");
	property p_inact_mask;
		@(posedge clk) disable iff (srst)
			(!cs_lo && out_sel == OUT_DEMOD && oef_en && !dem_s) |=> !demod_data_out;
	endproperty
	a_inact_mask: assert property (p_inact_mask) else $error("inactivity leaked with filter on");
	property p_clamp_mask;
		@(posedge clk) disable iff (srst) cmd_done_q |=> ((clamp_o ^ $past(clamp_o)) & ~$past(ch_en)) == 3'h0;
	endproperty
	a_clamp_mask: assert property (p_clamp_mask) else $error("clamp touched disabled channel");
endmodule : lfp_pin_ctrl

// File: sim/lfp_host_model.sv
// Serial host model driving chip select, link clock and data pin.
// Assumes the bench resolves both shared pins from all enables.
`timescale 1ns/1ps
module lfp_host_model import lfp_pkg::*; (
	input wire logic sdio_pin,
	output logic cs_n,
	output logic sclk,
	output logic sclk_en,
	output logic sdio
);
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		sclk_en = 1'b0;
		sdio = 1'b0;
	end
	////////////////////////////////////////////////////////////////////////////////
	// 15 clocks of 64 ns, MSB first; data held 50 ns past each rise
	task automatic frame(input logic [2:0] cmd, input logic [2:0] adr, input logic [8:0] wd,
		output logic [8:0] rd);
		logic [14:0] bits;
		bits = {cmd, adr, wd};
		rd = 9'h000;
		cs_n = 1'b0;
		#100;
		sclk_en = 1'b1;
		for (int i = 14; i >= 0; i--) begin
			// Released line toggles so a stale level never passes as data
			sdio = (cmd == CMD_READ && i < 9) ? ~sdio : bits[i];
			#14 sclk = 1'b1;
			#32 sclk = 1'b0;
			#6;
			if (i >= 1 && i <= 9)
				rd = {rd[7:0], sdio_pin};
			#12;
		end
		#100;
		sclk_en = 1'b0;
		cs_n = 1'b1;
		#500;
	endtask : frame
endmodule : lfp_host_model

// File: sim/lfp_pin_ctrl_test.sv
// Bench for the shared-pin control: host frames and field stimulus.
// Assumes a pull-up on the clock/alert pin and a short alarm time.
`timescale 1ns/1ps
module lfp_pin_ctrl_test import lfp_pkg::*;;
	localparam int unsigned ALARM_T = 2000;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic demod = 1'b0;
	logic carrier = 1'b0;
	logic agc = 1'b0;
	logic inact = 1'b0;
	int err_total = 0;
	int cmp_count = 0;
	int n;
	logic [8:0] rd;
	logic cs_n, sclk, sclk_en, sdio, alert_o, alert_oe_n, dout, data_oe_n, rssi;
	logic [2:0] clamp;
	logic [2:0] ch_en;
	wire logic sclk_pin = sclk_en ? sclk : (alert_oe_n ? 1'b1 : alert_o);
	wire logic sdio_pin = data_oe_n ? sdio : dout;
	always #2.5 clk = ~clk;
	////////////////////////////////////////////////////////////////////////////////
	lfp_pin_ctrl #(.ALARM_CYCLES(ALARM_T)) lfp_pin_ctrl_inst (.clk(clk), .srst(srst),
		.cs_n_i(cs_n), .sclk_i(sclk_pin), .sdio_i(sdio_pin), .demod_i(demod),
		.carrier_i(carrier), .agc_settled_i(agc), .inact_tmo_i(inact), .alert_o(alert_o),
		.alert_oe_n(alert_oe_n), .demod_data_out(dout), .data_oe_n(data_oe_n),
		.rssi_sink_en(rssi), .clamp_o(clamp), .ch_en_o(ch_en));
	lfp_host_model lfp_host_model_inst (.sdio_pin(sdio_pin), .cs_n(cs_n), .sclk(sclk),
		.sclk_en(sclk_en), .sdio(sdio));
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : give_verdict
	task automatic xfer(input logic [2:0] cmd, input logic [2:0] a, input logic [8:0] v);
		lfp_host_model_inst.frame(cmd, a, v, rd);
		repeat (4) @(negedge clk);
	endtask : xfer
	task automatic fld(input logic d, input logic c, input logic a, input logic t,
		input logic exp);
		@(negedge clk);
		demod = d;
		carrier = c;
		agc = a;
		inact = t;
		repeat (5) @(negedge clk);
		chk(dout, exp);
	endtask : fld
	////////////////////////////////////////////////////////////////////////////////
	// Host owns the clock pin: the alert driver must be off
	always @(negedge clk)
		if (sclk_en)
			chk(alert_oe_n, 1'b1);
	initial begin
		repeat (60000) @(posedge clk);
		err_total++;
		give_verdict();
	end
	initial begin
		repeat (20) @(negedge clk);
		srst = 1'b0;
		repeat (2) @(negedge clk);
		chk(sclk_pin, 1'b1);
		chk(alert_o, 1'b0);
		chk(data_oe_n, 1'b0);
		chk(rssi, 1'b0);
		xfer(CMD_WRITE, ADDR_CHAN, 9'h141);
		chk(ch_en, 3'h5);
		xfer(CMD_CLAMP_ON, ADDR_CHAN, 9'h000);
		chk(clamp, 3'h5);
		xfer(CMD_CLAMP_OFF, ADDR_CHAN, 9'h000);
		chk(clamp, 3'h0);
		xfer(CMD_READ, ADDR_CHAN, 9'h000);
		chk(rd, 9'h141);
		xfer(CMD_WRITE, ADDR_STATUS, 9'h1FF);
		xfer(CMD_READ, ADDR_STATUS, 9'h000);
		chk(rd, 9'h000);
		xfer(CMD_WRITE, ADDR_OUT, 9'h040);
		fld(1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
		fld(1'b0, 1'b1, 1'b1, 1'b0, 1'b1);
		fld(1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
		xfer(CMD_WRITE, ADDR_OUT, 9'h001);
		fld(1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
		fld(1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
		xfer(CMD_WRITE, ADDR_OUT, 9'h100);
		fld(1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
		chk(rssi, 1'b0);
		xfer(CMD_WRITE, ADDR_OUT, 9'h080);
		chk(rssi, 1'b1);
		xfer(CMD_WRITE, ADDR_CHAN, 9'h140);
		chk(sclk_pin, 1'b0);
		xfer(CMD_READ, ADDR_STATUS, 9'h000);
		chk(rd, 9'h080);
		xfer(CMD_WRITE, ADDR_CHAN, 9'h141);
		chk(sclk_pin, 1'b1);
		// Alarm counts from the last header, some 250 cycles back
		n = 0;
		while (sclk_pin !== 1'b0 && n < ALARM_T + 100) begin
			@(negedge clk);
			n++;
		end
		chk(n >= ALARM_T - 300 && n <= ALARM_T, 1'b1);
		xfer(CMD_READ, ADDR_STATUS, 9'h000);
		chk(rd, 9'h100);
		chk(sclk_pin, 1'b1);
		give_verdict();
	end
endmodule : lfp_pin_ctrl_test
